/* File: verification/led_ctl_model.sv */
`timescale 1ns/1ps

module led_ctl_model (
    input wire logic clk_i, // bench clock
    input wire logic serial_out_i, // device serial out
    output logic sclk_o, // shift clock
    output logic sin_o, // serial data
    output logic strobe_o, // latch strobe
    output logic mode_o // chain select
);
    initial begin
        sclk_o = 1'b0;
        sin_o = 1'b0;
        strobe_o = 1'b0;
        mode_o = 1'b0;
    end

    // Shift n bits MSB first, capture what falls out, then latch
    task send(input logic m, input logic [111:0] d, input int n, output logic [111:0] q);
        q = '0;
        mode_o <= m;
        repeat (8) @(posedge clk_i);
        for (int i = n - 1; i >= 0; i--) begin
            sin_o <= d[i];
            repeat (20) @(posedge clk_i);
            q = {q[110:0], serial_out_i};
            sclk_o <= 1'b1;
            repeat (20) @(posedge clk_i);
            sclk_o <= 1'b0;
        end
        sin_o <= ~sin_o;
        repeat (20) @(posedge clk_i);
        strobe_o <= 1'b1;
        repeat (10) @(posedge clk_i);
        strobe_o <= 1'b0;
        repeat (10) @(posedge clk_i);
    endtask : send
endmodule : led_ctl_model

/* File: verification/led_sink_serial_control_tb.sv */
`timescale 1ns/1ps
`include "led_sink_params.svh"

module led_sink_serial_control_tb;
    import led_sink_pkg::*;
    logic clk, rst_b, force_off, ot, psel, pen, pwr, err;
    logic pready, pslverr, serial_out, sclk, serial_in, strobe, mode, fault, fault_oe, irq;
    logic [`NUM_CH-1:0] out_low, sink, onoff, open_led_flag;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [`TRIM_BITS-1:0] trim, q, tdat;
    int errors, compares;
    wire fault_pin = fault_oe ? 1'b1 : fault;

    led_sink_serial_control DUT (.REF_CLK_I(clk), .RST_B_I(rst_b), .SCLK_I(sclk),
        .SERIAL_IN_I(serial_in), .LATCH_STROBE_I(strobe), .MODE_I(mode), .FORCE_OFF_I(force_off),
        .OUT_LOW_I(out_low), .OVERTEMP_I(ot), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .SERIAL_OUT_O(serial_out), .SINK_OUTPUT_O(sink), .TRIM_O(trim),
        .FAULT_OUT_N_O(fault), .FAULT_OE_N_O(fault_oe), .IRQ_O(irq));
    led_ctl_model u_ctl (.clk_i(clk), .serial_out_i(serial_out), .sclk_o(sclk), .sin_o(serial_in),
        .strobe_o(strobe), .mode_o(mode));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    function automatic logic [15:0] exp_sink(input logic [15:0] on, input logic off);
        return off ? 16'h0000 : on;
    endfunction : exp_sink

    task close_out;
        $display("Mismatches %0d, compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out

    task chk(input logic [111:0] got, input logic [111:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1);
        chk(n, 1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        close_out;
    end

    initial begin
        errors = 0;
        compares = 0;
        {rst_b, ot, psel, pen, pwr, paddr, pwdata} = '0;
        force_off = 1'b1;
        out_low = '0;
        void'($urandom(89));
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        apb(1'b0, `ADDR_INT_MASK, 32'h0);
        chk(rd, 32'h0);
        onoff = 16'($urandom) | 16'h0001;
        for (int i = 0; i < `NUM_CH; i++) tdat[7*i +: 7] = 7'($urandom);
        tdat[6:0] = 7'h7F;
        u_ctl.send(1'b0, {96'h0, onoff}, 16, q);
        chk(sink, exp_sink(onoff, 1'b1));
        u_ctl.send(1'b1, tdat, 112, q);
        chk(trim, tdat);
        force_off <= 1'b0;
        repeat (6) @(posedge clk);
        chk(sink, exp_sink(onoff, 1'b0));
        // Restart turn-on so the open-LED sample sees the low outputs
        force_off <= 1'b1;
        out_low <= 16'($urandom) | 16'h0001;
        repeat (10) @(posedge clk);
        force_off <= 1'b0;
        open_led_flag = onoff & out_low;
        repeat (400) @(posedge clk);
        apb(1'b0, `ADDR_FLAGS, 32'h0);
        chk(rd[15:0], open_led_flag);
        chk(fault_pin, 1'b0);
        u_ctl.send(1'b0, {96'h0, onoff}, 16, q);
        u_ctl.send(1'b0, {96'h0, onoff}, 16, q);
        chk(q[15:0], open_led_flag);
        chk(trim, tdat);
        apb(1'b0, `ADDR_ONOFF, 32'h0);
        chk({err, rd}, {1'b0, 16'h0000, onoff});
        apb(1'b0, `ADDR_INT_STATUS, 32'h0);
        chk(rd, 32'h0000_0005);
        apb(1'b1, `ADDR_INT_MASK, 32'h1);
        repeat (3) @(posedge clk);
        chk(irq, 1'b1);
        apb(1'b1, `ADDR_INT_STATUS, 32'h7);
        repeat (3) @(posedge clk);
        chk(irq, 1'b0);
        force_off <= 1'b1;
        repeat (10) @(posedge clk);
        chk(fault_pin, 1'b1);
        ot <= 1'b1;
        repeat (10) @(posedge clk);
        chk(fault_pin, 1'b0);
        chk(irq, 1'b0);
        apb(1'b0, `ADDR_FLAGS, 32'h0);
        chk(rd[`FLAGS_OT_BIT], 1'b1);
        apb(1'b1, `ADDR_INT_MASK, 32'h2);
        repeat (3) @(posedge clk);
        chk(irq, 1'b1);
        apb(1'b0, 12'h010, 32'h0);
        chk({err, rd}, {1'b1, 32'h0});
        close_out;
    end
endmodule : led_sink_serial_control_tb

/* File: verilog/led_sink_params.svh */
`ifndef LED_SINK_PARAMS_SVH
`define LED_SINK_PARAMS_SVH

`define NUM_CH 16
`define TRIM_W 7
`define TRIM_BITS 112
`define SETTLE_W 8

`define CLK_PERIOD_PS 4000
`define LOD_SAMPLE_NS 1000
`define LOD_SAMPLE_CYC ((`LOD_SAMPLE_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`define ADDR_W 12
`define ADDR_INT_STATUS 12'h000
`define ADDR_INT_MASK 12'h004
`define ADDR_ONOFF 12'h008
`define ADDR_FLAGS 12'h00C

`define INT_W 3
`define INT_LOD_BIT 0
`define INT_OT_BIT 1
`define INT_LATCH_BIT 2
`define INT_MASK_RST 3'h0
`define FLAGS_OT_BIT 16

`endif

/* File: verilog/led_sink_pkg.sv */
`include "led_sink_params.svh"

package led_sink_pkg;

    typedef struct packed {
        logic [2:0] sclk_s;
        logic [2:0] latch_strobe_s;
        logic [1:0] sin_s;
        logic [1:0] mode_s;
        logic [1:0] blank_s;
        logic [2:0] ot_s;
        logic [1:0][`NUM_CH-1:0] vlow_s;
        logic [`NUM_CH-1:0] on_chain;
        logic [`TRIM_BITS-1:0] trim_chain;
        logic [`NUM_CH-1:0] on_hold;
        logic [`TRIM_BITS-1:0] trim_hold;
        logic [`NUM_CH-1:0] sink_on;
        logic [`NUM_CH-1:0][`SETTLE_W-1:0] settle;
        logic [`NUM_CH-1:0] open_led_flag;
        logic [`INT_W-1:0] int_status;
        logic [`INT_W-1:0] int_mask;
        logic irq;
        logic serial_out;
        logic fault_oe_n;
        logic fault_drv;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } state_t;

endpackage : led_sink_pkg

/* File: verilog/led_sink_serial_control.sv */
// Contract
// [RULE1] Force-off input high turns every sink output off.
// [RULE2] Force-off low: each output follows its latched on/off bit.
// [RULE3] Mode low routes serial port to on/off chain, high to trim chain.
// [RULE4] Each shift clock rise shifts the selected chain one bit from serial in. On/off chain takes open-LED status instead while latch strobe high.
// [RULE5] Latch strobe rise copies selected chain to its latches; other unchanged.
// [RULE6] Open-drain fault pin pulled low while open-LED or overtemp flag active.
// [RULE7] Sixteen channels, each with own on/off state and trim value.
// [RULE8] Trim value is seven bits, 128 current steps.
// [RULE9] Open-LED flag for broken LED, overtemp flag for hot die.
// [RULE10] Error status also readable through serial out.
// [RULE11] Controller shifts, latches, then enables outputs.
// [RULE12] Controller clocks 16 on/off bits or 112 trim bits.
// [RULE13] Controller keeps latch strobe low while shifting.
// [RULE14] On/off latch strobe loads open-LED status into on/off chain.
// [RULE15] Open LED flagged only if on and output low at sample time.
// [RULE16] Latched one turns output on, zero turns it off.
// [RULE17] Controller holds force-off high until both chains latched.
`timescale 1ns/1ps
`include "led_sink_params.svh"

module led_sink_serial_control
    import led_sink_pkg::*;
(
    input wire logic REF_CLK_I, // 250 MHz clock
    input wire logic RST_B_I, // sync reset, low
    input wire logic SCLK_I, // shift clock pin
    input wire logic SERIAL_IN_I, // serial data pin
    input wire logic LATCH_STROBE_I, // latch strobe pin
    input wire logic MODE_I, // chain select pin
    input wire logic FORCE_OFF_I, // force-all-off pin
    input wire logic [`NUM_CH-1:0] OUT_LOW_I, // output below threshold
    input wire logic OVERTEMP_I, // die overheat sense
    input wire logic PSEL_I, // APB select
    input wire logic PENABLE_I, // APB enable
    input wire logic PWRITE_I, // APB write
    input wire logic [`ADDR_W-1:0] PADDR_I, // APB address
    input wire logic [31:0] PWDATA_I, // APB write data
    output logic [31:0] PRDATA_O, // APB read data
    output logic PREADY_O, // APB ready
    output logic PSLVERR_O, // APB error
    output logic SERIAL_OUT_O, // serial data out
    output logic [`NUM_CH-1:0] SINK_OUTPUT_O, // sink on per channel
    output logic [`TRIM_BITS-1:0] TRIM_O, // 7-bit trim per channel
    output logic FAULT_OUT_N_O, // fault pin drive level
    output logic FAULT_OE_N_O, // fault pin enable, low
    output logic IRQ_O // interrupt level
);

    localparam logic [`SETTLE_W-1:0] LOD_CYC =
        `SETTLE_W'(`LOD_SAMPLE_CYC);

    state_t st_r;
    state_t st_nxt;

    logic sclk_rise;
    logic latch_strobe_rise;
    logic latch_strobe_hi;
    logic mode;
    logic apb_setup;
    logic apb_wr;
    logic [`INT_W-1:0] events;

    // Edges taken from the second and third stages only
    assign sclk_rise = st_r.sclk_s[1] & ~st_r.sclk_s[2];
    assign latch_strobe_rise = st_r.latch_strobe_s[1] & ~st_r.latch_strobe_s[2];
    assign latch_strobe_hi = st_r.latch_strobe_s[1];
    assign mode = st_r.mode_s[1];
    assign apb_setup = PSEL_I & ~PENABLE_I;
    assign apb_wr = PSEL_I & PENABLE_I & st_r.pready & PWRITE_I;

    always_comb begin
        st_nxt = st_r;

        st_nxt.sclk_s = {st_r.sclk_s[1:0], SCLK_I};
        st_nxt.latch_strobe_s = {st_r.latch_strobe_s[1:0], LATCH_STROBE_I};
        st_nxt.sin_s = {st_r.sin_s[0], SERIAL_IN_I};
        st_nxt.mode_s = {st_r.mode_s[0], MODE_I};
        st_nxt.blank_s = {st_r.blank_s[0], FORCE_OFF_I};
        st_nxt.ot_s = {st_r.ot_s[1:0], OVERTEMP_I};
        st_nxt.vlow_s = {st_r.vlow_s[0], OUT_LOW_I};

        // Shift path picked by mode
        if (sclk_rise && !mode) begin
            st_nxt.on_chain = {st_r.on_chain[`NUM_CH-2:0], st_r.sin_s[1]}; // RULE3 RULE4
        end
        if (sclk_rise && mode) begin
            st_nxt.trim_chain = {st_r.trim_chain[`TRIM_BITS-2:0], st_r.sin_s[1]}; // RULE4 RULE8
        end

        // Commit only the chain that mode selects
        if (latch_strobe_rise && !mode) begin
            st_nxt.on_hold = st_r.on_chain; // RULE5 RULE7
        end
        if (latch_strobe_rise && mode) begin
            st_nxt.trim_hold = st_r.trim_chain; // RULE5 RULE8
        end

        // Status readback; holding latch took the old chain above
        if (latch_strobe_hi && !mode) begin
            st_nxt.on_chain = st_r.open_led_flag; // RULE14 RULE10
        end

        st_nxt.serial_out = mode ? st_r.trim_chain[`TRIM_BITS-1] :
            st_r.on_chain[`NUM_CH-1]; // RULE3 RULE10

        st_nxt.sink_on = st_r.blank_s[1] ? '0 : st_r.on_hold; // RULE1 RULE2 RULE16

        // Sample each output once, one settle time after turn-on
        for (int i = 0; i < `NUM_CH; i++) begin
            if (!st_r.sink_on[i]) begin
                st_nxt.settle[i] = '0;
                st_nxt.open_led_flag[i] = 1'b0;
            end else if (st_r.settle[i] != LOD_CYC) begin
                st_nxt.settle[i] = st_r.settle[i] + `SETTLE_W'(1);
                if (st_r.settle[i] == LOD_CYC - `SETTLE_W'(1)) begin
                    st_nxt.open_led_flag[i] = st_r.vlow_s[1][i]; // RULE15 RULE9
                end
            end
        end

        st_nxt.fault_oe_n = ~((|st_r.open_led_flag) | st_r.ot_s[1]); // RULE6 RULE9
        st_nxt.fault_drv = 1'b0;

        events = '0;
        events[`INT_LOD_BIT] = (|st_nxt.open_led_flag) & ~(|st_r.open_led_flag);
        events[`INT_OT_BIT] = st_r.ot_s[1] & ~st_r.ot_s[2];
        events[`INT_LATCH_BIT] = latch_strobe_rise;

        st_nxt.pready = 1'b0;
        st_nxt.pslverr = 1'b0;
        if (apb_setup) begin
            st_nxt.pready = 1'b1;
            st_nxt.prdata = '0;
            unique case (PADDR_I)
                `ADDR_INT_STATUS: begin
                    st_nxt.prdata[`INT_W-1:0] = st_r.int_status;
                end
                `ADDR_INT_MASK: begin
                    st_nxt.prdata[`INT_W-1:0] = st_r.int_mask;
                end
                `ADDR_ONOFF: begin
                    st_nxt.prdata[`NUM_CH-1:0] = st_r.on_hold;
                end
                `ADDR_FLAGS: begin
                    st_nxt.prdata[`NUM_CH-1:0] = st_r.open_led_flag;
                    st_nxt.prdata[`FLAGS_OT_BIT] = st_r.ot_s[1];
                end
                default: begin
                    st_nxt.pslverr = 1'b1;
                end
            endcase
        end

        if (apb_wr && PADDR_I == `ADDR_INT_STATUS) begin
            st_nxt.int_status = st_r.int_status & ~PWDATA_I[`INT_W-1:0];
        end
        if (apb_wr && PADDR_I == `ADDR_INT_MASK) begin
            st_nxt.int_mask = PWDATA_I[`INT_W-1:0];
        end
        // New event beats a clear in the same cycle
        st_nxt.int_status = st_nxt.int_status | events;
        st_nxt.irq = |(st_nxt.int_status & st_nxt.int_mask);
    end

    always_ff @(posedge REF_CLK_I) begin
        if (!RST_B_I) begin
            st_r <= '0;
            st_r.fault_oe_n <= 1'b1;
            st_r.int_mask <= `INT_MASK_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign PRDATA_O = st_r.prdata;
    assign PREADY_O = st_r.pready;
    assign PSLVERR_O = st_r.pslverr;
    assign SERIAL_OUT_O = st_r.serial_out;
    assign SINK_OUTPUT_O = st_r.sink_on;
    assign TRIM_O = st_r.trim_hold;
    assign FAULT_OUT_N_O = st_r.fault_drv;
    assign FAULT_OE_N_O = st_r.fault_oe_n;
    assign IRQ_O = st_r.irq;

    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (!RST_B_I);

    property p_force_off;
        st_r.blank_s[1] |=> (SINK_OUTPUT_O == '0);
    endproperty
    a_force_off: assert property (p_force_off) // RULE1
        else $error("sink output on while forced off");

    property p_follow_latch;
        !st_r.blank_s[1] |=> (SINK_OUTPUT_O == $past(st_r.on_hold));
    endproperty
    a_follow_latch: assert property (p_follow_latch) // RULE2
        else $error("sink output differs from latched bit");

    property p_shift_onoff;
        (sclk_rise && !mode && !latch_strobe_hi) |=>
            (st_r.on_chain == {$past(st_r.on_chain[`NUM_CH-2:0]), $past(st_r.sin_s[1])})
            && $stable(st_r.trim_chain);
    endproperty
    a_shift_onoff: assert property (p_shift_onoff) // RULE3
        else $error("on/off chain shift wrong");

    property p_shift_trim;
        (sclk_rise && mode) |=>
            (st_r.trim_chain[0] == $past(st_r.sin_s[1]))
            && (st_r.trim_chain[`TRIM_BITS-1:1] == $past(st_r.trim_chain[`TRIM_BITS-2:0]));
    endproperty
    a_shift_trim: assert property (p_shift_trim) // RULE4
        else $error("trim chain shift wrong");

    property p_latch_sel;
        latch_strobe_rise |=> (mode ? (st_r.trim_hold == $past(st_r.trim_chain))
            && $stable(st_r.on_hold)
            : (st_r.on_hold == $past(st_r.on_chain)) && $stable(st_r.trim_hold));
    endproperty
    a_latch_sel: assert property (p_latch_sel) // RULE5
        else $error("latch strobe committed wrong chain");

    property p_lod_load;
        (latch_strobe_rise && !mode) |=> (st_r.on_chain == $past(st_r.open_led_flag));
    endproperty
    a_lod_load: assert property (p_lod_load) // RULE14
        else $error("open-LED status not loaded into chain");

    property p_fault;
        ((|st_r.open_led_flag) || st_r.ot_s[1]) |=> !FAULT_OE_N_O ##0 !FAULT_OUT_N_O;
    endproperty
    a_fault: assert property (p_fault) // RULE6
        else $error("fault pin not pulled low");

    property p_fault_rel;
        (!(|st_r.open_led_flag) && !st_r.ot_s[1]) |=> FAULT_OE_N_O;
    endproperty
    a_fault_rel: assert property (p_fault_rel) // RULE6
        else $error("fault pin pulled with no flag");

    property p_lod_detect;
        (st_r.sink_on[0] && st_r.settle[0] == LOD_CYC - `SETTLE_W'(1)
            && st_r.vlow_s[1][0]) |=> st_r.open_led_flag[0];
    endproperty
    a_lod_detect: assert property (p_lod_detect) // RULE15
        else $error("open LED on channel 0 missed");

    property p_lod_off;
        !st_r.sink_on[0] |=> !st_r.open_led_flag[0];
    endproperty
    a_lod_off: assert property (p_lod_off) // RULE15
        else $error("open LED flagged on an off channel");

    property p_serial_out;
        ##1 (SERIAL_OUT_O == (($past(mode)) ? $past(st_r.trim_chain[`TRIM_BITS-1])
            : $past(st_r.on_chain[`NUM_CH-1])));
    endproperty
    a_serial_out: assert property (p_serial_out) // RULE10
        else $error("serial out not from selected chain");

    property p_irq;
        (|(st_r.int_status & st_r.int_mask)) |-> IRQ_O;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt low with unmasked status");

    // Register bus, interrupt and holding-latch checks
    property p_ready_pulse;
        apb_setup |=> PREADY_O ##1 !PREADY_O;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("ready not a single-cycle answer to setup");

    property p_err_unmapped;
        apb_setup |=> (PSLVERR_O == !($past(PADDR_I) inside {`ADDR_INT_STATUS,
            `ADDR_INT_MASK, `ADDR_ONOFF, `ADDR_FLAGS}));
    endproperty
    a_err_unmapped: assert property (p_err_unmapped)
        else $error("error response does not match address map");

    property p_onoff_read;
        (apb_setup && PADDR_I == `ADDR_ONOFF) |=>
            (PRDATA_O == {16'h0000, $past(st_r.on_hold)});
    endproperty
    a_onoff_read: assert property (p_onoff_read) // RULE7
        else $error("on/off readback differs from latches");

    property p_mask_write;
        (apb_wr && PADDR_I == `ADDR_INT_MASK) |=>
            (st_r.int_mask == $past(PWDATA_I[`INT_W-1:0]));
    endproperty
    a_mask_write: assert property (p_mask_write)
        else $error("mask write not applied");

    property p_w1c_set_wins;
        (apb_wr && PADDR_I == `ADDR_INT_STATUS) |=>
            ((st_r.int_status & $past(events)) == $past(events))
            && ((st_r.int_status & $past(PWDATA_I[`INT_W-1:0]) & ~$past(events)) == '0);
    endproperty
    a_w1c_set_wins: assert property (p_w1c_set_wins)
        else $error("status clear wrong or beat a new event");

    property p_ot_status;
        (st_r.ot_s[1] && !st_r.ot_s[2]) |=> st_r.int_status[`INT_OT_BIT];
    endproperty
    a_ot_status: assert property (p_ot_status) // RULE9
        else $error("overtemp event not recorded");

    property p_latch_status;
        latch_strobe_rise |=> st_r.int_status[`INT_LATCH_BIT];
    endproperty
    a_latch_status: assert property (p_latch_status)
        else $error("latch event not recorded");

    property p_hold_stable;
        !latch_strobe_rise |=> $stable(st_r.on_hold) && $stable(TRIM_O);
    endproperty
    a_hold_stable: assert property (p_hold_stable) // RULE5
        else $error("holding latch changed without strobe");

    // Open-LED checks on every channel, not only channel 0
    for (genvar ch = 0; ch < `NUM_CH; ch++) begin : g_lod_chk
        property p_lod_sample;
            (st_r.sink_on[ch] && st_r.settle[ch] == LOD_CYC - `SETTLE_W'(1)) |=>
                (st_r.open_led_flag[ch] == $past(st_r.vlow_s[1][ch]));
        endproperty
        a_lod_sample: assert property (p_lod_sample) // RULE15
            else $error("open-LED sample wrong on a channel");

        property p_lod_hold;
            (!st_r.open_led_flag[ch] && !(st_r.sink_on[ch]
                && st_r.settle[ch] == LOD_CYC - `SETTLE_W'(1))) |=> !st_r.open_led_flag[ch];
        endproperty
        a_lod_hold: assert property (p_lod_hold) // RULE15
            else $error("open-LED flag set outside its sample");
    end

    c_latch_onoff: cover property (latch_strobe_rise && !mode);
    c_latch_trim: cover property (latch_strobe_rise && mode);
    c_lod_seen: cover property ($rose(|st_r.open_led_flag));
    c_irq: cover property ($rose(IRQ_O));
    c_ot_seen: cover property ($rose(st_r.ot_s[1]));

endmodule : led_sink_serial_control
